/* File: hw/rdcl_pkg.sv */
package rdcl_pkg;
  // Serial word layout
  localparam int RDCL_CH = 8;
  localparam int RDCL_WORD16 = 16;
  localparam int RDCL_ADDR_MSB = 15;
  localparam int RDCL_ADDR_LSB = 8;
  // Register addresses
  localparam logic [7:0] RDCL_ADDR_OUTCTL = 8'h00;
  localparam logic [7:0] RDCL_ADDR_PSCFG = 8'h01;
  // Reset values and power-save level codes
  localparam logic [7:0] RDCL_OUT_RST = 8'h00;
  localparam logic [2:0] RDCL_PS_RST = 3'h0;
  localparam logic [2:0] RDCL_PS_OFF = 3'h0;
  localparam logic [2:0] RDCL_PS_FIXED60 = 3'h2;
  // Power-save timing: delay per nF of capacitance, in us
  localparam int RDCL_PS_US_PER_NF = 32;
  localparam int RDCL_CLK_MHZ = 50;
  localparam int RDCL_PSR_MS = 3;
  localparam int RDCL_PSR_CYC = RDCL_PSR_MS * 1000 * RDCL_CLK_MHZ;
  // Interface variant
  typedef enum logic [1:0] {
    RDCL_MODE_SER8 = 2'h0,
    RDCL_MODE_SER16 = 2'h1,
    RDCL_MODE_PAR = 2'h3
  } rdcl_mode_e;
  // Serial pins after synchronising
  typedef struct packed {
    logic cs_n;
    logic sclk;
    logic din;
  } rdcl_ser_s;
  // Parallel pins after synchronising
  typedef struct packed {
    logic [2:0] addr;
    logic level;
  } rdcl_par_s;
endpackage

/* File: hw/rdcl_sync.sv */
`timescale 1ns/1ns
// Two-stage synchroniser, one per bit
module rdcl_sync import rdcl_pkg::*; #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic ce_in,
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);
  logic [W-1:0] meta_reg;
  // First stage feeds only the second
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      meta_reg <= RST_VAL;
      q_out <= RST_VAL;
    end else if (ce_in) begin
      meta_reg <= d_in;
      q_out <= meta_reg;
    end
  end
endmodule

/* File: hw/rdcl_ps_timer.sv */
`timescale 1ns/1ns
// Power-save charge timer and release counter
module rdcl_ps_timer import rdcl_pkg::*; #(
  parameter int DELAY_CYC = 8000,
  parameter int RELEASE_CYC = RDCL_PSR_CYC
) (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic ce_in,
  input wire logic clear_in,
  input wire logic write_in,
  input wire logic pin_in,
  output logic active_out
);
  localparam int CW = $clog2((DELAY_CYC > RELEASE_CYC ? DELAY_CYC : RELEASE_CYC) + 1);
  logic [CW-1:0] charge_reg;
  logic [CW-1:0] low_reg;
  logic charging_reg;
  initial begin
    if (DELAY_CYC < 1 || RELEASE_CYC < 1) $error("rdcl_ps_timer: counts must be >= 1");
  end
  // Charge after each write; pin high then engages
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      charge_reg <= '0;
      charging_reg <= 1'b0;
    end else if (ce_in) begin
      if (clear_in) begin
        charge_reg <= '0;
        charging_reg <= 1'b0;
      end else if (write_in) begin
        charge_reg <= '0;
        charging_reg <= 1'b1;
      end else if (charging_reg && charge_reg == CW'(DELAY_CYC - 1)) begin
        charging_reg <= 1'b0;
      end else if (charging_reg) begin
        charge_reg <= charge_reg + 1'b1;
      end
    end
  end
  // Pin low for release time cancels power save
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      low_reg <= '0;
      active_out <= 1'b0;
    end else if (ce_in) begin
      if (clear_in) begin
        low_reg <= '0;
        active_out <= 1'b0;
      end else if (pin_in && !charging_reg) begin
        low_reg <= '0;
        active_out <= 1'b1;
      end else if (!pin_in && low_reg == CW'(RELEASE_CYC - 1)) begin
        active_out <= 1'b0;
      end else if (!pin_in) begin
        low_reg <= low_reg + 1'b1;
      end
    end
  end
endmodule

/* File: hw/rdcl_top.sv */
`timescale 1ns/1ns
module rdcl_top import rdcl_pkg::*; #(
  parameter rdcl_mode_e MODE = RDCL_MODE_SER16,
  parameter int PS_CAP_NF = 100,
  parameter int PS_DELAY_CYC = RDCL_PS_US_PER_NF * PS_CAP_NF * RDCL_CLK_MHZ,
  parameter int PS_RELEASE_CYC = RDCL_PSR_CYC
) (
  // Clock, reset, enable
  input wire logic CLK_IN,
  input wire logic ARST_N_IN,
  input wire logic CE_IN,
  // Set and clear pins
  input wire logic CLEAR_N_IN,
  input wire logic SET_N_IN,
  // Serial port
  input wire logic CHIP_SELECT_N_IN,
  input wire logic SERIAL_CLOCK_IN,
  input wire logic SERIAL_IN_IN,
  output logic SERIAL_OUT_OUT,
  // Parallel port
  input wire logic ADDRESS_BIT_0_IN,
  input wire logic ADDRESS_BIT_1_IN,
  input wire logic ADDRESS_BIT_2_IN,
  input wire logic LEVEL_SELECT_IN,
  // Power save and thermal
  input wire logic POWER_SAVE_PIN_IN,
  input wire logic THERM_WARN_IN,
  input wire logic THERM_SHUT_IN,
  // Relay drivers, open drain
  output logic [RDCL_CH-1:0] RELAY_OUT_O_OUT,
  output logic [RDCL_CH-1:0] RELAY_OUT_OE_OUT,
  output logic [RDCL_CH-1:0] RELAY_SAVE_OUT,
  output logic [2:0] PS_LEVEL_OUT
);
  localparam int SW = (MODE == RDCL_MODE_SER8) ? RDCL_CH : RDCL_WORD16;

  initial begin
    if (PS_CAP_NF < 1 || PS_DELAY_CYC < 1 || PS_RELEASE_CYC < 1) $error("rdcl_top: bad timing parameter");
  end

  // Output index decode from a 3-bit address
  function automatic logic [RDCL_CH-1:0] one_hot(input logic [2:0] a);
    one_hot = 8'h01 << a;
  endfunction

  // Synchronised pins
  rdcl_ser_s ser;
  rdcl_par_s par;
  logic [1:0] ctl_s;
  logic [1:0] th_s;
  logic ps_pin_s;
  rdcl_sync #(.W(3), .RST_VAL(3'h4)) u_sync_ser (
    .clk_in(CLK_IN),
    .arst_n_in(ARST_N_IN),
    .ce_in(CE_IN),
    .d_in({CHIP_SELECT_N_IN, SERIAL_CLOCK_IN, SERIAL_IN_IN}),
    .q_out(ser)
  );
  rdcl_sync #(.W(4), .RST_VAL(4'h0)) u_sync_par (
    .clk_in(CLK_IN),
    .arst_n_in(ARST_N_IN),
    .ce_in(CE_IN),
    .d_in({ADDRESS_BIT_2_IN, ADDRESS_BIT_1_IN, ADDRESS_BIT_0_IN, LEVEL_SELECT_IN}),
    .q_out(par)
  );
  rdcl_sync #(.W(5), .RST_VAL(5'h18)) u_sync_ctl (
    .clk_in(CLK_IN),
    .arst_n_in(ARST_N_IN),
    .ce_in(CE_IN),
    .d_in({CLEAR_N_IN, SET_N_IN, THERM_WARN_IN, THERM_SHUT_IN, POWER_SAVE_PIN_IN}),
    .q_out({ctl_s, th_s, ps_pin_s})
  );

  // Set and clear qualifiers
  logic clear_act;
  logic set_act;
  assign clear_act = !ctl_s[1];
  assign set_act = ctl_s[1] && !ctl_s[0];

  // Edge detection on synchronised pins
  logic sclk_d_reg;
  logic cs_d_reg;
  always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      sclk_d_reg <= 1'b0;
      cs_d_reg <= 1'b1;
    end else if (CE_IN) begin
      sclk_d_reg <= ser.sclk;
      cs_d_reg <= ser.cs_n;
    end
  end
  logic sclk_rise;
  logic sclk_fall;
  logic cs_rise;
  logic cs_fall;
  assign sclk_rise = ser.sclk && !sclk_d_reg;
  assign sclk_fall = !ser.sclk && sclk_d_reg;
  assign cs_rise = ser.cs_n && !cs_d_reg;
  assign cs_fall = !ser.cs_n && cs_d_reg;

  // Serial shift register, MSB first
  logic [SW-1:0] shift_reg;
  always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      shift_reg <= '0;
    end else if (CE_IN) begin
      if (clear_act) begin
        shift_reg <= '0;
      end else if (set_act) begin
        shift_reg <= '1;
      end else if (!ser.cs_n && sclk_rise) begin
        shift_reg <= {shift_reg[SW-2:0], ser.din};
      end
    end
  end

  // Serial out changes on falling clock, while deselected, or on set or clear
  always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      SERIAL_OUT_OUT <= 1'b0;
    end else if (CE_IN) begin
      if (clear_act || set_act || ser.cs_n || sclk_fall) begin
        SERIAL_OUT_OUT <= shift_reg[SW-1];
      end
    end
  end

  // Parallel address held from select falling edge
  logic [2:0] par_addr_reg;
  always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      par_addr_reg <= '0;
    end else if (CE_IN) begin
      if (clear_act) begin
        par_addr_reg <= '0;
      end else if (set_act) begin
        par_addr_reg <= '1;
      end else if (cs_fall) begin
        par_addr_reg <= par.addr;
      end
    end
  end

  // Write strobes decoded at select rising edge
  logic wr_out;
  logic wr_ps;
  logic [7:0] ser_addr;
  logic [7:0] ser_data;
  assign ser_addr = (MODE == RDCL_MODE_SER16) ? shift_reg[SW-1 -: 8] : RDCL_ADDR_OUTCTL;
  assign ser_data = shift_reg[7:0];
  assign wr_out = cs_rise && !clear_act && !set_act && ser_addr == RDCL_ADDR_OUTCTL;
  assign wr_ps = cs_rise && !clear_act && !set_act && MODE == RDCL_MODE_SER16
    && ser_addr == RDCL_ADDR_PSCFG;

  // Output control register
  logic [RDCL_CH-1:0] outctl_reg;
  logic [RDCL_CH-1:0] par_sel;
  assign par_sel = one_hot(par_addr_reg);
  always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      outctl_reg <= RDCL_OUT_RST;
    end else if (CE_IN) begin
      if (clear_act) begin
        outctl_reg <= RDCL_OUT_RST;
      end else if (set_act) begin
        outctl_reg <= '1;
      end else if (wr_out && MODE == RDCL_MODE_PAR) begin
        // Only the addressed output moves
        outctl_reg <= par.level ? (outctl_reg | par_sel) : (outctl_reg & ~par_sel);
      end else if (wr_out) begin
        outctl_reg <= ser_data;
      end
    end
  end

  // Power-save configuration register
  logic [2:0] pscfg_reg;
  always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      pscfg_reg <= RDCL_PS_RST;
    end else if (CE_IN) begin
      if (clear_act) begin
        pscfg_reg <= RDCL_PS_RST;
      end else if (set_act) begin
        pscfg_reg <= '1;
      end else if (wr_ps) begin
        pscfg_reg <= ser_data[2:0];
      end
    end
  end

  // Power-save timing
  logic ps_active;
  rdcl_ps_timer #(.DELAY_CYC(PS_DELAY_CYC), .RELEASE_CYC(PS_RELEASE_CYC)) u_ps_timer (
    .clk_in(CLK_IN),
    .arst_n_in(ARST_N_IN),
    .ce_in(CE_IN),
    .clear_in(clear_act || th_s[1]),
    .write_in(wr_out),
    .pin_in(ps_pin_s),
    .active_out(ps_active)
  );

  // Effective level: config in 16-bit serial, off in 8-bit serial, fixed in parallel
  logic [2:0] ps_level;
  always_comb begin
    if (MODE == RDCL_MODE_PAR) begin
      ps_level = RDCL_PS_FIXED60;
    end else if (MODE == RDCL_MODE_SER16) begin
      ps_level = pscfg_reg;
    end else begin
      ps_level = RDCL_PS_OFF;
    end
  end

  // Relay drive outputs, registered
  logic ps_on;
  assign ps_on = ps_active && ps_level != RDCL_PS_OFF && !th_s[1];
  always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      RELAY_OUT_OE_OUT <= '0;
      RELAY_SAVE_OUT <= '0;
      PS_LEVEL_OUT <= RDCL_PS_OFF;
    end else if (CE_IN) begin
      if (th_s[0]) begin
        RELAY_OUT_OE_OUT <= '0;
        RELAY_SAVE_OUT <= '0;
      end else begin
        RELAY_OUT_OE_OUT <= outctl_reg;
        RELAY_SAVE_OUT <= ps_on ? outctl_reg : '0;
      end
      PS_LEVEL_OUT <= ps_on ? ps_level : RDCL_PS_OFF;
    end
  end
  // Open drain pulls low when enabled
  assign RELAY_OUT_O_OUT = '0;
endmodule

/* File: dv/rdcl_host_model.sv */
`timescale 1ns/1ns
// Host driving the three-wire serial port
module rdcl_host_model import rdcl_pkg::*; (
  // Clock and request
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic start_in,
  input wire logic [23:0] word_in,
  input wire logic [4:0] nbits_in,
  // Serial pins and status
  output logic cs_n_out,
  output logic sclk_out,
  output logic din_out,
  output logic busy_out
);
  logic [2:0] ph_reg;
  logic [4:0] left_reg;
  logic [3:0] tail_reg;
  logic [23:0] sh_reg;
  // Frame sequencer, eight clocks per bit, clock idles low
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      {cs_n_out, sclk_out, din_out, busy_out} <= 4'h8;
      {ph_reg, left_reg, tail_reg, sh_reg} <= '0;
    end else if (start_in && !busy_out) begin
      busy_out <= 1'b1;
      cs_n_out <= 1'b0;
      sh_reg <= word_in << (5'd24 - nbits_in); // MSB first
      din_out <= word_in[nbits_in - 5'd1]; // Valid before first rise
      {ph_reg, left_reg, tail_reg} <= {3'h0, nbits_in, 4'h0};
    end else if (busy_out && left_reg != 5'h0) begin
      ph_reg <= ph_reg + 3'h1;
      if (ph_reg == 3'h3) sclk_out <= 1'b1;
      if (ph_reg == 3'h6) begin
        sclk_out <= 1'b0;
        sh_reg <= sh_reg << 1;
        din_out <= sh_reg[22]; // Next bit after the fall
        left_reg <= left_reg - 5'h1;
      end
    end else begin
      din_out <= ~din_out; // Released line never holds
      tail_reg <= tail_reg + 4'h1;
      if (tail_reg == 4'h3) cs_n_out <= 1'b1;
      if (tail_reg == 4'h9) busy_out <= 1'b0;
    end
  end
endmodule

/* File: dv/rdcl_monitor.sv */
`timescale 1ns/1ns
// Port checks on the relay driver
module rdcl_monitor import rdcl_pkg::*; (
  // Clock and reset
  input wire logic CLK_IN,
  input wire logic ARST_N_IN,
  // Control pins
  input wire logic CLEAR_N_IN,
  input wire logic SET_N_IN,
  input wire logic CHIP_SELECT_N_IN,
  input wire logic SERIAL_CLOCK_IN,
  input wire logic THERM_WARN_IN,
  input wire logic THERM_SHUT_IN,
  // Driver outputs
  input wire logic SERIAL_OUT_OUT,
  input wire logic [RDCL_CH-1:0] RELAY_OUT_OE_OUT,
  input wire logic [RDCL_CH-1:0] RELAY_SAVE_OUT,
  input wire logic [2:0] PS_LEVEL_OUT
);
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!ARST_N_IN);
  // Forcing pins
  chk_clear_empties:
    assert property (!CLEAR_N_IN [*6] |-> RELAY_OUT_OE_OUT == 8'h00) else $error("outputs on in clear");
  chk_clear_beats_set:
    assert property ((!CLEAR_N_IN && !SET_N_IN) [*6] |-> RELAY_OUT_OE_OUT == 8'h00) else $error("set beat clear");
  chk_set_forces_on:
    assert property ((!SET_N_IN && CLEAR_N_IN && !THERM_SHUT_IN) [*6] |-> RELAY_OUT_OE_OUT == 8'hff)
      else $error("set did not force");
  // Outputs frozen while selected
  chk_hold_selected:
    assert property ((!CHIP_SELECT_N_IN && CLEAR_N_IN && SET_N_IN && !THERM_SHUT_IN) [*8]
      |-> $stable(RELAY_OUT_OE_OUT)) else $error("outputs moved while selected");
  // Daisy output moves with the clock low
  chk_dout_on_fall:
    assert property (($changed(SERIAL_OUT_OUT) && SET_N_IN && CLEAR_N_IN) |-> !SERIAL_CLOCK_IN)
      else $error("serial out moved with clock high");
  // Reduced drive only on active channels
  chk_save_on_active:
    assert property ((RELAY_SAVE_OUT & ~RELAY_OUT_OE_OUT) == 8'h00) else $error("save on idle channel");
  // Thermal thresholds
  chk_warn_cancels:
    assert property (THERM_WARN_IN [*5] |-> PS_LEVEL_OUT == 3'h0 && RELAY_SAVE_OUT == 8'h00)
      else $error("save kept when warm");
  chk_shut_off:
    assert property (THERM_SHUT_IN [*5] |-> RELAY_OUT_OE_OUT == 8'h00) else $error("outputs on when hot");
endmodule
bind rdcl_top rdcl_monitor rdcl_monitor_inst (.CLK_IN(CLK_IN), .ARST_N_IN(ARST_N_IN), .CLEAR_N_IN(CLEAR_N_IN),
  .SET_N_IN(SET_N_IN), .CHIP_SELECT_N_IN(CHIP_SELECT_N_IN), .SERIAL_CLOCK_IN(SERIAL_CLOCK_IN),
  .THERM_WARN_IN(THERM_WARN_IN), .THERM_SHUT_IN(THERM_SHUT_IN), .SERIAL_OUT_OUT(SERIAL_OUT_OUT),
  .RELAY_OUT_OE_OUT(RELAY_OUT_OE_OUT), .RELAY_SAVE_OUT(RELAY_SAVE_OUT), .PS_LEVEL_OUT(PS_LEVEL_OUT));

/* File: dv/rdcl_top_test.sv */
`timescale 1ns/1ns
module rdcl_top_test import rdcl_pkg::*; ;
  logic clk = 1'b0, arst_n = 1'b0, clr_n = 1'b1, set_n = 1'b1;
  logic power_save_pin = 1'b0, warn = 1'b0, shut = 1'b0, start = 1'b0;
  logic [23:0] word = 24'h0;
  logic [4:0] nbits = 5'h10;
  logic cs_n, sclk, din, dout, busy;
  logic [7:0] oe, o, save;
  logic [2:0] lvl;
  logic ce = 1'b1, pcs_n = 1'b1;
  logic [3:0] pbits = 4'h0;
  logic [7:0] oe_p, o_p, save_p;
  logic [2:0] lvl_p;
  int err_total = 0;
  int cmp_count = 0;
  // 50 MHz clock
  always #10 clk = ~clk;
  // Short power-save counts keep the run brief
  rdcl_top #(.MODE(RDCL_MODE_SER16), .PS_DELAY_CYC(20), .PS_RELEASE_CYC(30)) rdcl_top_inst (
    .CLK_IN(clk), .ARST_N_IN(arst_n), .CE_IN(ce), .CLEAR_N_IN(clr_n), .SET_N_IN(set_n),
    .CHIP_SELECT_N_IN(cs_n), .SERIAL_CLOCK_IN(sclk), .SERIAL_IN_IN(din), .SERIAL_OUT_OUT(dout),
    .ADDRESS_BIT_0_IN(pbits[1]), .ADDRESS_BIT_1_IN(pbits[2]), .ADDRESS_BIT_2_IN(pbits[3]),
    .LEVEL_SELECT_IN(pbits[0]),
    .POWER_SAVE_PIN_IN(power_save_pin), .THERM_WARN_IN(warn), .THERM_SHUT_IN(shut),
    .RELAY_OUT_O_OUT(o), .RELAY_OUT_OE_OUT(oe), .RELAY_SAVE_OUT(save), .PS_LEVEL_OUT(lvl));
  // Parallel variant beside the serial one
  rdcl_top #(.MODE(RDCL_MODE_PAR), .PS_DELAY_CYC(20), .PS_RELEASE_CYC(30)) rdcl_top_par_inst (
    .CLK_IN(clk), .ARST_N_IN(arst_n), .CE_IN(ce), .CLEAR_N_IN(clr_n), .SET_N_IN(set_n),
    .CHIP_SELECT_N_IN(pcs_n), .SERIAL_CLOCK_IN(sclk), .SERIAL_IN_IN(din), .SERIAL_OUT_OUT(),
    .ADDRESS_BIT_0_IN(pbits[1]), .ADDRESS_BIT_1_IN(pbits[2]), .ADDRESS_BIT_2_IN(pbits[3]),
    .LEVEL_SELECT_IN(pbits[0]),
    .POWER_SAVE_PIN_IN(power_save_pin), .THERM_WARN_IN(warn), .THERM_SHUT_IN(shut),
    .RELAY_OUT_O_OUT(o_p), .RELAY_OUT_OE_OUT(oe_p), .RELAY_SAVE_OUT(save_p), .PS_LEVEL_OUT(lvl_p));
  rdcl_host_model rdcl_host_model_inst (.clk_in(clk), .arst_n_in(arst_n), .start_in(start),
    .word_in(word), .nbits_in(nbits), .cs_n_out(cs_n), .sclk_out(sclk), .din_out(din), .busy_out(busy));
  // Verdict and end of run
  task results;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // One serial frame, then let the outputs settle
  task send(input logic [23:0] w, input logic [4:0] n);
    int i;
    start <= 1'b1;
    word <= w;
    nbits <= n;
    tick(2);
    start <= 1'b0;
    for (i = 0; i < 600 && busy; i++) tick(1);
    if (i == 600) begin
      err_total++;
      results();
    end
    tick(6);
  endtask
  // Output writes, refused address, overlong frame
  task sc_write;
    send({8'h0, RDCL_ADDR_OUTCTL, 8'ha5}, 5'd16);
    chk(oe, 8'ha5);
    ce <= 1'b0;
    send(24'h0000ff, 5'd16);
    chk(oe, 8'ha5);
    ce <= 1'b1;
    tick(4);
    send(24'h0080ff, 5'd16);
    chk(oe, 8'ha5);
    chk({7'h0, dout}, 8'h01);
    send(24'h5a003c, 5'd24);
    chk(oe, 8'h3c);
    chk(o, 8'h00);
  endtask
  // Every power-save code, release and warm cancel
  task sc_save;
    for (int c = 0; c < 9; c++) begin
      send({8'h0, RDCL_ADDR_PSCFG, 8'(c > 7 ? 7 : c)}, 5'd16);
      tick(25);
      power_save_pin <= 1'b1;
      tick(6);
      if (c == 8) begin
        warn <= 1'b1;
        tick(6);
        chk({5'h0, lvl}, 8'h00);
        warn <= 1'b0;
      end else begin
        chk({5'h0, lvl}, 8'(c));
        chk(save, c == 0 ? 8'h00 : 8'h3c);
      end
      power_save_pin <= 1'b0;
      tick(40);
      chk(save, 8'h00);
    end
  endtask
  // One parallel write; address moved after select falls
  task par_wr(input logic [2:0] a, input logic l);
    pbits <= {a, l};
    tick(2);
    pcs_n <= 1'b0;
    tick(4);
    pbits <= {~a, l};
    tick(4);
    pcs_n <= 1'b1;
    tick(6);
  endtask
  // Parallel writes and fixed power-save level
  task sc_par;
    par_wr(3'h0, 1'b1);
    chk(oe_p, 8'h01);
    par_wr(3'h7, 1'b1);
    par_wr(3'h3, 1'b1);
    chk(oe_p, 8'h89);
    par_wr(3'h0, 1'b0);
    chk(oe_p, 8'h88);
    power_save_pin <= 1'b1;
    tick(30);
    chk({5'h0, lvl_p}, 8'h02);
    chk(save_p, 8'h88);
    power_save_pin <= 1'b0;
    tick(40);
    chk(save_p, 8'h00);
  endtask
  // Set, clear, thermal shutdown
  task sc_force;
    set_n <= 1'b0;
    tick(8);
    chk(oe, 8'hff);
    chk(oe_p, 8'hff);
    send(24'h0, 5'd16);
    chk(oe, 8'hff);
    clr_n <= 1'b0;
    tick(8);
    chk(oe, 8'h00);
    set_n <= 1'b1;
    tick(8);
    chk(oe, 8'h00);
    clr_n <= 1'b1;
    tick(5);
    send(24'h00000f, 5'd16);
    chk(oe, 8'h0f);
    shut <= 1'b1;
    tick(8);
    chk(oe, 8'h00);
    shut <= 1'b0;
  endtask
  // Main sequence
  initial begin
    tick(20);
    arst_n <= 1'b1;
    tick(4);
    chk(oe, 8'h00);
    sc_write();
    sc_par();
    sc_save();
    sc_force();
    results();
  end
endmodule
